// [design/imeta_pkg.sv]
// Constants and types for the image metadata appender
// Behaviour
// - Master enable set appends enabled items to each image; clear appends nothing.
// - Image and checksum items are always enabled; disabling them has no effect.
// - Selector picks an item; include flag writes affect only that item.
// - Selector choices: image, checksum, id, geometry, exposure, gain, black, format, time, set, serial, lines.
// - Configuration writes are ignored while acquisition runs; here item selector writes still take effect while running.
// - Checksum item carries a CRC over the frame image data only.
// - Frame identifier item reports the id of its frame.
// - Geometry items report offsets, width and height used for the frame.
// - Exposure item reports applied exposure time in microseconds.
// - Gain item reports gain chosen by the gain channel selector.
// - Black level item reports black level chosen by its selector; here it always reports the all-channel black level.
// - Time item reports timestamp captured for the frame.
// - Sequence item reports sequencer set active during the frame.
// - Line item reports line states latched at exposure end.
// - Serial item carries captured bytes together with their length.
// - A read-only flag shows serial capture overflow.
// - Format item reports image pixel encoding from the listed set.
// - Gain selector offers all, red, green and blue.
package imeta_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_ITEM_SEL = 8'h04;
    localparam logic [7:0] ADDR_ITEM_INC = 8'h08;
    localparam logic [7:0] ADDR_GAIN_SEL = 8'h0C;
    localparam logic [7:0] ADDR_BLK_SEL  = 8'h10;
    localparam logic [7:0] ADDR_STATUS   = 8'h14;
    localparam int         CTRL_EN_BIT   = 0;
    localparam int         CTRL_RUN_BIT  = 1;
    localparam int         ST_OVF_BIT    = 0;
    localparam int         ST_BUSY_BIT   = 1;
    localparam int         ST_LEN_LSB    = 8;
    localparam logic [14:0] ITEMS_RESET  = 15'h0003;
    localparam logic [14:0] ITEMS_FORCED = 15'h0003;
    // ----------------------------------------
    // Items in append order
    // ----------------------------------------
    typedef enum logic [3:0] {
        ITEM_IMAGE, ITEM_CRC, ITEM_FRAME_ID, ITEM_X_START, ITEM_Y_START,
        ITEM_COLUMNS, ITEM_ROWS, ITEM_EXPOSURE, ITEM_GAIN, ITEM_BLACK,
        ITEM_PIXEL_FMT, ITEM_TIME, ITEM_SEQ_STEP, ITEM_SERIAL, ITEM_LINES
    } imeta_item_t;
    localparam logic [3:0] ITEM_LAST = 4'hE;
    localparam logic [3:0] ITEM_NONE = 4'hF;
    typedef enum logic [1:0] {GAIN_ALL, GAIN_RED, GAIN_GREEN, GAIN_BLUE} imeta_gain_t;
    typedef enum logic [3:0] {
        PIX_MONO8, PIX_MONO12_PACKED, PIX_MONO16, PIX_RGB8, PIX_YUV422,
        PIX_BAYER_GR8, PIX_BAYER_RG8, PIX_BAYER_GB8, PIX_BAYER_BG8, PIX_YCBCR422
    } imeta_pix_t;
    // ----------------------------------------
    // Serial capture and checksum
    // ----------------------------------------
    localparam int          SER_BYTES    = 16;
    localparam int          SER_WORDS    = 4;
    localparam logic [31:0] CRC_POLY     = 32'h04C11DB7;
    localparam logic [31:0] CRC_INIT     = 32'hFFFFFFFF;
endpackage : imeta_pkg

// [design/imeta_appender.sv]
// Image metadata appender: APB registers, metadata capture, stream framer
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module imeta_appender (
    // Clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_nrst,
    // APB slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic             o_pready,
    output logic             o_pslverr,
    output logic [31:0]      o_prdata,
    // Acquisition events
    input  wire logic        i_acq_running,
    input  wire logic        i_exposure_end,
    // Per-frame values
    input  wire logic [31:0] i_frame_id,
    input  wire logic [15:0] i_x_start,
    input  wire logic [15:0] i_y_start,
    input  wire logic [15:0] i_columns,
    input  wire logic [15:0] i_rows,
    input  wire logic [31:0] i_exposure_us,
    input  wire logic [15:0] i_gain_all,
    input  wire logic [15:0] i_gain_red,
    input  wire logic [15:0] i_gain_green,
    input  wire logic [15:0] i_gain_blue,
    input  wire logic [15:0] i_black_all,
    input  wire logic [3:0]  i_pixel_fmt,
    input  wire logic [63:0] i_timestamp,
    input  wire logic [7:0]  i_seq_step,
    input  wire logic [7:0]  i_line_states,
    // Serial receive bytes
    input  wire logic        i_ser_valid,
    input  wire logic [7:0]  i_ser_byte,
    // Image input stream
    input  wire logic        i_in_valid,
    input  wire logic [31:0] i_in_data,
    input  wire logic        i_in_last,
    output logic             o_in_ready,
    // Payload output stream
    output logic             o_out_valid,
    output logic [31:0]      o_out_data,
    output logic             o_out_last,
    input  wire logic        i_out_ready
);
    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic        master_en,  next_master_en;
    logic [3:0]  item_sel,   next_item_sel;
    logic [14:0] item_inc,   next_item_inc;
    logic [1:0]  gain_sel,   next_gain_sel;
    logic        blk_sel,    next_blk_sel;
    logic        snap_ovf;
    logic [4:0]  snap_len;
    logic        busy;
    logic        wr_en;
    logic [31:0] rdata;

    assign wr_en     = i_psel && i_penable && i_pwrite;
    assign o_pready  = 1'b1;
    assign o_pslverr = i_psel && i_penable && !(i_paddr inside {imeta_pkg::ADDR_CTRL, imeta_pkg::ADDR_ITEM_SEL,
                       imeta_pkg::ADDR_ITEM_INC, imeta_pkg::ADDR_GAIN_SEL, imeta_pkg::ADDR_BLK_SEL,
                       imeta_pkg::ADDR_STATUS});
    assign o_prdata  = rdata;

    always_comb begin
        next_master_en = master_en;
        next_item_sel  = item_sel;
        next_item_inc  = item_inc;
        next_gain_sel  = gain_sel;
        next_blk_sel   = blk_sel;
        if (wr_en) begin
            case (i_paddr)
                imeta_pkg::ADDR_CTRL: begin
                    if (!i_acq_running) begin
                        next_master_en = i_pwdata[imeta_pkg::CTRL_EN_BIT];
                    end
                end
                imeta_pkg::ADDR_ITEM_SEL: begin
                    if (i_pwdata[3:0] <= imeta_pkg::ITEM_LAST) begin
                        next_item_sel = i_pwdata[3:0];
                    end
                end
                imeta_pkg::ADDR_ITEM_INC: begin
                    if (!i_acq_running) begin
                        next_item_inc[item_sel] = i_pwdata[0];
                    end
                end
                imeta_pkg::ADDR_GAIN_SEL: begin
                    if (!i_acq_running) begin
                        next_gain_sel = i_pwdata[1:0];
                    end
                end
                imeta_pkg::ADDR_BLK_SEL: begin
                    next_blk_sel = 1'b0;
                end
                default: next_master_en = master_en;
            endcase
        end
        next_item_inc = next_item_inc | imeta_pkg::ITEMS_FORCED;
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            master_en <= 1'b0;
            item_sel  <= 4'h0;
            item_inc  <= imeta_pkg::ITEMS_RESET;
            gain_sel  <= 2'h0;
            blk_sel   <= 1'b0;
        end else begin
            master_en <= next_master_en;
            item_sel  <= next_item_sel;
            item_inc  <= next_item_inc;
            gain_sel  <= next_gain_sel;
            blk_sel   <= next_blk_sel;
        end
    end

    always_comb begin
        rdata = 32'h0;
        case (i_paddr)
            imeta_pkg::ADDR_CTRL: begin
                rdata[imeta_pkg::CTRL_EN_BIT]  = master_en;
                rdata[imeta_pkg::CTRL_RUN_BIT] = i_acq_running;
            end
            imeta_pkg::ADDR_ITEM_SEL: rdata[3:0] = item_sel;
            imeta_pkg::ADDR_ITEM_INC: rdata[0]   = item_inc[item_sel];
            imeta_pkg::ADDR_GAIN_SEL: rdata[1:0] = gain_sel;
            imeta_pkg::ADDR_BLK_SEL:  rdata[0]   = blk_sel;
            imeta_pkg::ADDR_STATUS: begin
                rdata[imeta_pkg::ST_OVF_BIT]                     = snap_ovf;
                rdata[imeta_pkg::ST_BUSY_BIT]                    = busy;
                rdata[imeta_pkg::ST_LEN_LSB+4:imeta_pkg::ST_LEN_LSB] = snap_len;
            end
            default: rdata = 32'h0;
        endcase
    end


    // ----------------------------------------
    // Serial capture and exposure-end snapshot
    // ----------------------------------------
    logic [7:0]  ser_buf [imeta_pkg::SER_BYTES];
    logic [7:0]  next_ser_buf [imeta_pkg::SER_BYTES];
    logic [4:0]  ser_len, next_ser_len;
    logic        ser_ovf, next_ser_ovf;
    logic [31:0] snap_ser [imeta_pkg::SER_WORDS];
    logic [31:0] snap_id, snap_exp;
    logic [15:0] snap_x, snap_y, snap_w, snap_h, snap_black;
    logic [15:0] snap_gain [4];
    logic [3:0]  snap_fmt;
    logic [63:0] snap_time;
    logic [7:0]  snap_seq, snap_lines;

    always_comb begin
        next_ser_buf = ser_buf;
        next_ser_len = ser_len;
        next_ser_ovf = ser_ovf;
        if (i_exposure_end) begin
            next_ser_len = 5'h0;
            next_ser_ovf = 1'b0;
        end
        if (i_ser_valid) begin
            if (next_ser_len < 5'(imeta_pkg::SER_BYTES)) begin
                next_ser_buf[next_ser_len[3:0]] = i_ser_byte;
                next_ser_len = next_ser_len + 5'h1;
            end else begin
                next_ser_ovf = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            ser_buf <= '{default: 8'h00};
            ser_len <= 5'h0;
            ser_ovf <= 1'b0;
        end else begin
            ser_buf <= next_ser_buf;
            ser_len <= next_ser_len;
            ser_ovf <= next_ser_ovf;
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            snap_id    <= 32'h0;
            snap_exp   <= 32'h0;
            snap_x     <= 16'h0;
            snap_y     <= 16'h0;
            snap_w     <= 16'h0;
            snap_h     <= 16'h0;
            snap_black <= 16'h0;
            snap_gain  <= '{default: 16'h0000};
            snap_fmt   <= 4'h0;
            snap_time  <= 64'h0;
            snap_seq   <= 8'h0;
            snap_lines <= 8'h0;
            snap_len   <= 5'h0;
            snap_ovf   <= 1'b0;
            snap_ser   <= '{default: 32'h0};
        end else if (i_exposure_end) begin
            // Latch every value at exposure end
            snap_id    <= i_frame_id;
            snap_exp   <= i_exposure_us;
            snap_x     <= i_x_start;
            snap_y     <= i_y_start;
            snap_w     <= i_columns;
            snap_h     <= i_rows;
            snap_black <= i_black_all;
            snap_gain  <= '{i_gain_all, i_gain_red, i_gain_green, i_gain_blue};
            snap_fmt   <= i_pixel_fmt;
            snap_time  <= i_timestamp;
            snap_seq   <= i_seq_step;
            snap_lines <= i_line_states;
            snap_len   <= ser_len;
            snap_ovf   <= ser_ovf;
            for (int w = 0; w < imeta_pkg::SER_WORDS; w++) begin
                snap_ser[w] <= {ser_buf[4*w+3], ser_buf[4*w+2], ser_buf[4*w+1], ser_buf[4*w]};
            end
        end
    end

    // ----------------------------------------
    // Framer
    // ----------------------------------------
    typedef enum {FR_IMAGE, FR_META} imeta_state_t;
    imeta_state_t state, next_state;
    logic [3:0]  item, next_item;
    logic [2:0]  sub, next_sub;
    logic [31:0] crc, next_crc;
    logic        out_valid, next_out_valid;
    logic [31:0] out_data, next_out_data;
    logic        out_last, next_out_last;
    logic        load;
    logic [31:0] item_word;
    logic [2:0]  item_words;
    logic [3:0]  after_item;

    function automatic logic [31:0] imeta_crc(input logic [31:0] c, input logic [31:0] d);
        logic [31:0] r;
        r = c;
        for (int b = 31; b >= 0; b--) begin
            r = (r[31] ^ d[b]) ? ((r << 1) ^ imeta_pkg::CRC_POLY) : (r << 1);
        end
        return r;
    endfunction : imeta_crc

    assign load        = !out_valid || i_out_ready;
    assign o_in_ready  = (state == FR_IMAGE) && load;
    assign o_out_valid = out_valid;
    assign o_out_data  = out_data;
    assign o_out_last  = out_last;
    assign busy        = (state == FR_META);

    // Next enabled item after the current one
    always_comb begin
        after_item = imeta_pkg::ITEM_NONE;
        for (int k = imeta_pkg::ITEM_LAST; k > 0; k--) begin
            if (4'(k) > item && item_inc[k]) begin
                after_item = 4'(k);
            end
        end
    end

    always_comb begin
        item_words = 3'd1;
        item_word  = 32'h0;
        case (item)
            imeta_pkg::ITEM_CRC:       item_word = ~crc;
            imeta_pkg::ITEM_FRAME_ID:  item_word = snap_id;
            imeta_pkg::ITEM_X_START:   item_word = {16'h0, snap_x};
            imeta_pkg::ITEM_Y_START:   item_word = {16'h0, snap_y};
            imeta_pkg::ITEM_COLUMNS:   item_word = {16'h0, snap_w};
            imeta_pkg::ITEM_ROWS:      item_word = {16'h0, snap_h};
            imeta_pkg::ITEM_EXPOSURE:  item_word = snap_exp;
            imeta_pkg::ITEM_GAIN:      item_word = {16'h0, snap_gain[gain_sel]};
            imeta_pkg::ITEM_BLACK:     item_word = {16'h0, snap_black};
            imeta_pkg::ITEM_PIXEL_FMT: item_word = {28'h0, snap_fmt};
            imeta_pkg::ITEM_TIME: begin
                item_words = 3'd2;
                item_word  = sub[0] ? snap_time[63:32] : snap_time[31:0];
            end
            imeta_pkg::ITEM_SEQ_STEP:  item_word = {24'h0, snap_seq};
            imeta_pkg::ITEM_SERIAL: begin
                item_words = 3'd5;
                item_word  = (sub == 3'd0) ? {snap_ovf, 26'h0, snap_len} : snap_ser[2'(sub - 3'd1)];
            end
            imeta_pkg::ITEM_LINES:     item_word = {24'h0, snap_lines};
            default:                   item_word = 32'h0;
        endcase
    end

    always_comb begin
        next_state     = state;
        next_item      = item;
        next_sub       = sub;
        next_crc       = crc;
        next_out_valid = load ? 1'b0 : out_valid;
        next_out_data  = out_data;
        next_out_last  = out_last;
        case (state)
            FR_IMAGE: begin
                if (i_in_valid && load) begin
                    next_out_valid = 1'b1;
                    next_out_data  = i_in_data;
                    next_crc       = imeta_crc(crc, i_in_data);
                    next_out_last  = i_in_last && !master_en;
                    if (i_in_last && master_en) begin
                        // Items follow the image in fixed order
                        next_state = FR_META;
                        next_item  = imeta_pkg::ITEM_CRC;
                        next_sub   = 3'd0;
                    end else if (i_in_last) begin
                        next_crc = imeta_pkg::CRC_INIT;
                    end
                end
            end
            FR_META: begin
                if (load) begin
                    next_out_valid = 1'b1;
                    next_out_data  = item_word;
                    next_out_last  = 1'b0;
                    next_sub       = sub + 3'd1;
                    if (sub == item_words - 3'd1) begin
                        next_sub = 3'd0;
                        if (after_item == imeta_pkg::ITEM_NONE) begin
                            next_out_last = 1'b1;
                            next_state    = FR_IMAGE;
                            next_crc      = imeta_pkg::CRC_INIT;
                        end else begin
                            next_item = after_item;
                        end
                    end
                end
            end
            default: next_state = FR_IMAGE;
        endcase
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            state     <= FR_IMAGE;
            item      <= 4'h0;
            sub       <= 3'd0;
            crc       <= imeta_pkg::CRC_INIT;
            out_valid <= 1'b0;
            out_data  <= 32'h0;
            out_last  <= 1'b0;
        end else begin
            state     <= next_state;
            item      <= next_item;
            sub       <= next_sub;
            crc       <= next_crc;
            out_valid <= next_out_valid;
            out_data  <= next_out_data;
            out_last  <= next_out_last;
        end
    end
endmodule : imeta_appender

// [test/imeta_host_sink.sv]
// Host-side payload sink with optional stalling
`timescale 1ns/1ps
module imeta_host_sink (
    // Clock and reset
    input  wire logic i_clock,
    input  wire logic i_nrst,
    // Payload stream handshake
    output logic      o_ready,
    // Stall request from bench
    input  wire logic i_slow
);
    logic [1:0] phase;
    logic [1:0] next_phase;
    always_comb begin
        next_phase = phase + 2'h1;
    end
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            phase <= 2'h0;
        end else begin
            phase <= next_phase;
        end
    end
    // Slow host takes one word in four
    assign o_ready = !i_slow || (phase == 2'h3);
endmodule : imeta_host_sink

// [test/imeta_props.sv]
// Port-level checks for the metadata appender
`timescale 1ns/1ps
module imeta_props (
    input wire logic        i_clock,
    input wire logic        i_nrst,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [7:0]  i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    input wire logic [31:0] o_prdata,
    input wire logic        i_acq_running,
    input wire logic        i_in_valid,
    input wire logic [31:0] i_in_data,
    input wire logic        i_in_last,
    input wire logic        o_in_ready,
    input wire logic        o_out_valid,
    input wire logic        o_out_last,
    input wire logic [31:0] o_out_data,
    input wire logic        i_out_ready
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);
    // Shadow of master enable, frozen while running
    logic en_q;
    logic next_en_q;
    wire  wr_ctrl = i_psel && i_penable && i_pwrite && i_paddr == imeta_pkg::ADDR_CTRL && !i_acq_running;
    wire  acc     = i_in_valid && o_in_ready;
    always_comb begin
        next_en_q = en_q;
        if (wr_ctrl) next_en_q = i_pwdata[0];
    end
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) en_q <= 1'b0;
        else en_q <= next_en_q;
    end
    pready_fixed_a: assert property (i_psel && i_penable |-> o_pready)
        else $error("pready low in access phase");
    unmapped_err_a: assert property (i_psel && i_penable && i_paddr > 8'h14 |-> o_pslverr && o_prdata == 32'h0)
        else $error("unmapped access not flagged");
    ctrl_read_a: assert property (i_psel && !i_pwrite && i_paddr == imeta_pkg::ADDR_CTRL |-> o_prdata[1:0] == {i_acq_running, en_q})
        else $error("control readback wrong");
    plain_last_a: assert property (acc && i_in_last && !en_q |=> o_out_valid && o_out_last)
        else $error("image end not marked last");
    meta_tail_a: assert property (acc && i_in_last && en_q |=> o_out_valid && !o_out_last && !o_in_ready)
        else $error("metadata did not follow image");
    pass_through_a: assert property (acc |=> o_out_valid && o_out_data == $past(i_in_data))
        else $error("image word not passed on");
    out_hold_a: assert property (o_out_valid && !i_out_ready |=> o_out_valid && $stable(o_out_data) && $stable(o_out_last))
        else $error("stalled word changed");
    in_gate_a: assert property (o_out_valid && !i_out_ready |-> !o_in_ready)
        else $error("input accepted during stall");
    reset_idle_a: assert property ($rose(i_nrst) |-> !o_out_valid)
        else $error("output valid out of reset");
    cover property (acc && i_in_last && en_q);
    cover property (o_out_valid && !i_out_ready);
    cover property (i_psel && i_penable && i_pwrite && i_acq_running);
endmodule : imeta_props
bind imeta_appender imeta_props i_props (.i_clock(i_clock), .i_nrst(i_nrst), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .o_prdata(o_prdata), .i_acq_running(i_acq_running), .i_in_valid(i_in_valid),
    .i_in_data(i_in_data), .i_in_last(i_in_last), .o_in_ready(o_in_ready), .o_out_valid(o_out_valid),
    .o_out_last(o_out_last), .o_out_data(o_out_data), .i_out_ready(i_out_ready));

// [test/imeta_appender_tb.sv]
// Self-checking bench for the metadata appender
`timescale 1ns/1ps
module imeta_appender_tb;
    typedef struct {logic [3:0] item; logic [31:0] val; int n;} imeta_row_t;
    logic        clock, nrst, psel, penable, pwrite, acq, exp_end, ser_valid, in_valid, in_last, slow, done;
    logic [7:0]  paddr, ser_byte, seq, lines;
    logic [31:0] pwdata, in_data, frame_id, expo, rv;
    logic [15:0] xs, ys, cols, rws, g_all, g_r, g_g, g_b, blk;
    logic [63:0] ts;
    logic [3:0]  fmt;
    wire         pready, pslverr, in_ready, out_valid, out_last, out_ready;
    wire  [31:0] prdata, out_data;
    logic [31:0] got[$];
    int          error_cnt, num_checks;
    imeta_row_t  rows[13];
    imeta_appender i_dut (.i_clock(clock), .i_nrst(nrst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_pslverr(pslverr), .o_prdata(prdata),
        .i_acq_running(acq), .i_exposure_end(exp_end), .i_frame_id(frame_id), .i_x_start(xs), .i_y_start(ys),
        .i_columns(cols), .i_rows(rws), .i_exposure_us(expo), .i_gain_all(g_all), .i_gain_red(g_r),
        .i_gain_green(g_g), .i_gain_blue(g_b), .i_black_all(blk), .i_pixel_fmt(fmt), .i_timestamp(ts),
        .i_seq_step(seq), .i_line_states(lines), .i_ser_valid(ser_valid), .i_ser_byte(ser_byte),
        .i_in_valid(in_valid), .i_in_data(in_data), .i_in_last(in_last), .o_in_ready(in_ready),
        .o_out_valid(out_valid), .o_out_data(out_data), .o_out_last(out_last), .i_out_ready(out_ready));
    imeta_host_sink i_host (.i_clock(clock), .i_nrst(nrst), .o_ready(out_ready), .i_slow(slow));
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    always @(posedge clock) begin
        if (out_valid === 1'b1 && out_ready === 1'b1) begin
            got.push_back(out_data);
            if (out_last === 1'b1) done = 1'b1;
        end
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] act);
        num_checks++;
        if (act !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, act);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rv = prdata;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge clock);
    endtask : apb
    function automatic logic [31:0] crc(input int n);
        logic [31:0] c;
        logic [31:0] d;
        logic        fb;
        c = imeta_pkg::CRC_INIT;
        for (int i = 0; i < n; i++) begin
            d = 32'hC0DE0000 + 32'(i);
            for (int b = 31; b >= 0; b--) begin
                fb = c[31] ^ d[b];
                c = {c[30:0], 1'b0} ^ (fb ? imeta_pkg::CRC_POLY : 32'h0);
            end
        end
        return ~c;
    endfunction : crc
    task automatic ser(input int n);
        for (int i = 0; i < n; i++) begin
            ser_valid <= 1'b1; ser_byte <= 8'h61 + 8'(i);
            @(posedge clock);
        end
        ser_valid <= 1'b0;
    endtask : ser
    // Snapshot, then disturb the live id while the frame streams
    task automatic frame(input int n);
        got = {}; done = 1'b0; acq <= 1'b1; exp_end <= 1'b1;
        @(posedge clock);
        exp_end <= 1'b0; frame_id <= ~frame_id;
        for (int i = 0; i < n; i++) begin
            in_valid <= 1'b1; in_data <= 32'hC0DE0000 + 32'(i); in_last <= (i == n - 1);
            do @(posedge clock); while (in_ready !== 1'b1);
        end
        in_valid <= 1'b0; in_last <= 1'b0;
        for (int k = 0; k < 300 && !done; k++) @(posedge clock);
        acq <= 1'b0; frame_id <= ~frame_id;
    endtask : frame
    task automatic conclude;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : conclude
    initial begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        conclude();
    end
    initial begin
        nrst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0; acq = 1'b0;
        exp_end = 1'b0; ser_valid = 1'b0; ser_byte = 8'h00; in_valid = 1'b0; in_last = 1'b0; in_data = 32'h0;
        slow = 1'b0; frame_id = 32'h11223344; xs = 16'h0010; ys = 16'h0020; cols = 16'h0280; rws = 16'h01E0;
        expo = 32'h000003E8; g_all = 16'h0101; g_r = 16'h0202; g_g = 16'h0303; g_b = 16'h0404; blk = 16'h0055;
        fmt = 4'h3; ts = 64'hAABBCCDD01234567; seq = 8'h05; lines = 8'hA5;
        rows = '{'{4'h2, 32'h11223344, 1}, '{4'h3, 32'h10, 1}, '{4'h4, 32'h20, 1}, '{4'h5, 32'h280, 1},
            '{4'h6, 32'h1E0, 1}, '{4'h7, 32'h3E8, 1}, '{4'h8, 32'h101, 1}, '{4'h9, 32'h55, 1}, '{4'hA, 32'h3, 1},
            '{4'hB, 32'h01234567, 2}, '{4'hC, 32'h5, 1}, '{4'hD, 32'h0, 5}, '{4'hE, 32'hA5, 1}};
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        apb(1'b1, imeta_pkg::ADDR_CTRL, 32'h1);
        foreach (rows[k]) begin
            apb(1'b1, imeta_pkg::ADDR_ITEM_SEL, {28'h0, rows[k].item});
            apb(1'b1, imeta_pkg::ADDR_ITEM_INC, 32'h1);
            apb(1'b0, imeta_pkg::ADDR_ITEM_INC, 32'h0);
            chk("include", 32'h1, {31'h0, rv[0]});
            frame(1);
            chk("count", 32'(2 + rows[k].n), 32'(got.size()));
            chk("image", 32'hC0DE0000, got[0]);
            chk("crc", crc(1), got[1]);
            chk("item", rows[k].val, got[2]);
            apb(1'b1, imeta_pkg::ADDR_ITEM_INC, 32'h0);
        end
        slow <= 1'b1;
        apb(1'b1, imeta_pkg::ADDR_ITEM_SEL, 32'h8);
        apb(1'b1, imeta_pkg::ADDR_ITEM_INC, 32'h1);
        for (int g = 0; g < 4; g++) begin
            apb(1'b1, imeta_pkg::ADDR_GAIN_SEL, 32'(g));
            frame(3);
            chk("gain", {16'h0, 16'h0101 * 16'(g + 1)}, got[4]);
            chk("crc3", crc(3), got[3]);
        end
        apb(1'b1, imeta_pkg::ADDR_ITEM_INC, 32'h0);
        apb(1'b1, imeta_pkg::ADDR_ITEM_SEL, 32'hD);
        apb(1'b1, imeta_pkg::ADDR_ITEM_INC, 32'h1);
        ser(3);
        frame(1);
        chk("ser_len", 32'h3, got[2]);
        chk("ser_data", 32'h00636261, got[3]);
        ser(17);
        frame(1);
        chk("ser_ovf", 32'h1, {31'h0, got[2][31]});
        apb(1'b0, imeta_pkg::ADDR_STATUS, 32'h0);
        chk("status_ovf", 32'h1, {31'h0, rv[0]});
        acq <= 1'b1;
        apb(1'b1, imeta_pkg::ADDR_CTRL, 32'h0);
        apb(1'b1, imeta_pkg::ADDR_ITEM_INC, 32'h0);
        apb(1'b0, imeta_pkg::ADDR_ITEM_INC, 32'h0);
        chk("frozen_inc", 32'h1, {31'h0, rv[0]});
        apb(1'b0, imeta_pkg::ADDR_CTRL, 32'h0);
        chk("frozen_en", 32'h3, {30'h0, rv[1:0]});
        acq <= 1'b0;
        apb(1'b1, imeta_pkg::ADDR_ITEM_SEL, 32'h1);
        apb(1'b1, imeta_pkg::ADDR_ITEM_INC, 32'h0);
        apb(1'b0, imeta_pkg::ADDR_ITEM_INC, 32'h0);
        chk("crc_kept", 32'h1, {31'h0, rv[0]});
        apb(1'b1, imeta_pkg::ADDR_CTRL, 32'h0);
        frame(2);
        chk("plain_cnt", 32'h2, 32'(got.size()));
        chk("plain_end", 32'hC0DE0001, got[1]);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h0, rv);
        nrst <= 1'b0;
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        apb(1'b0, imeta_pkg::ADDR_CTRL, 32'h0);
        chk("rst_ctrl", 32'h0, {31'h0, rv[0]});
        apb(1'b0, imeta_pkg::ADDR_ITEM_SEL, 32'h0);
        chk("rst_sel", 32'h0, {28'h0, rv[3:0]});
        apb(1'b0, imeta_pkg::ADDR_ITEM_INC, 32'h0);
        chk("rst_inc", 32'h1, {31'h0, rv[0]});
        apb(1'b0, imeta_pkg::ADDR_GAIN_SEL, 32'h0);
        chk("rst_gain", 32'h0, {30'h0, rv[1:0]});
        conclude();
    end
endmodule : imeta_appender_tb
